// file: hdl/snvm_params.svh
`ifndef SNVM_PARAMS_SVH
`define SNVM_PARAMS_SVH

// Command codes
`define SNVM_OP_SET_WPL      8'h06
`define SNVM_OP_CLR_WPL      8'h04
`define SNVM_OP_READ_STATE   8'h05
`define SNVM_OP_WRITE_STATE  8'h01
`define SNVM_OP_READ_MEM     8'h03
`define SNVM_OP_WRITE_MEM    8'h02

// State byte field positions
`define SNVM_ST_GUARD_EN     7
`define SNVM_ST_SPARE_HI     6
`define SNVM_ST_SPARE_LO     4
`define SNVM_ST_REGION_HI    3
`define SNVM_ST_REGION_LO    2
`define SNVM_ST_WPL          1
`define SNVM_ST_ZERO         0
`define SNVM_NV_INIT         6'h00

`define SNVM_MEM_DEPTH       16384

// Controller register byte offsets
`define SNVM_REG_CTRL        8'h00
`define SNVM_REG_TXD         8'h04
`define SNVM_REG_STAT        8'h08
`define SNVM_REG_DIV         8'h0C

// Control and status register bit positions
`define SNVM_CTRL_START      0
`define SNVM_CTRL_KEEP_SEL   1
`define SNVM_CTRL_IDLE_HIGH  2
`define SNVM_CTRL_PAUSE      3
`define SNVM_CTRL_WP_LEVEL   4
`define SNVM_STAT_BUSY       8

// Link timing
`define SNVM_CLK_NS          4
`define SNVM_SCK_HALF_MIN_NS 20
`define SNVM_SCK_HALF_MIN_CYC \
    ((`SNVM_SCK_HALF_MIN_NS + `SNVM_CLK_NS - 1) / `SNVM_CLK_NS)
`define SNVM_DIV_RESET       8'h0F

`define SNVM_RESP_OKAY       2'h0
`define SNVM_RESP_SLVERR     2'h2

`endif

// file: hdl/snvm_pkg.sv
package snvm_pkg;

    typedef logic [7:0] snvm_byte_t;

    typedef enum logic [2:0] {
        DEV_CMD,
        DEV_ADDR_HI,
        DEV_ADDR_LO,
        DEV_WDATA,
        DEV_RDATA,
        DEV_RSTATE,
        DEV_WSTATE,
        DEV_SKIP
    } snvm_dev_state_e;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_SETUP,
        HST_LOW,
        HST_HIGH,
        HST_END
    } snvm_host_state_e;

endpackage

// file: hdl/snvm_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface snvm_link_if;
    logic sel_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic pause_n;
    logic wp_n;

    modport dev (
        input  sel_n,
        input  sck,
        input  si,
        input  pause_n,
        input  wp_n,
        output so,
        output so_oe
    );

    modport host (
        output sel_n,
        output sck,
        output si,
        output pause_n,
        output wp_n,
        input  so,
        input  so_oe
    );
endinterface

`default_nettype wire

// file: hdl/snvm_device.sv
// Contract
// - Deselected: output floated, all inputs ignored
// - Host selects before first command bit
// - Pause floats output, ignores clock and input
// - Host keeps select low while paused
// - Sample on rising, shift out on falling
// - Host sends command, address, then data
// - Idle clock low or high both work
// - Device is a slave only
// - Host may tie input and output together
// - Bit 7 guard-enable, nonvolatile, guards state
// - Bits 6..4 spare, nonvolatile, start 000
// - Bits 3..2 select guarded array region
// - Bit 1 latch: set/clear commands only
// - Latch clears at power-on, clear, write end
// - Bit 0 always reads zero
// - Array holds 16384 bytes of eight bits
// - Writes finish with no busy time
// - Six eight-bit command codes
// - State write ignores incoming bits 1, 0
// - Region codes guard none, quarter, half, all
// - Latch gates all writes; guard-enable and pin gate state writes
`timescale 1ns/10ps
`default_nettype none
`include "snvm_params.svh"

module snvm_device #(
    parameter int DEPTH = `SNVM_MEM_DEPTH
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    snvm_link_if.dev             link,
    output logic [7:0]           state_byte,
    output logic                 selected
);
    import snvm_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Region guard decode, used only by the array write path
    function automatic logic region_locked(input logic [1:0] code,
                                           input logic [AW-1:0] a);
        logic hit;
        hit = 1'b0;
        case (code)
            2'b01:   hit = (a[AW-1:AW-2] == 2'b11);
            2'b10:   hit = a[AW-1];
            2'b11:   hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Pin synchroniser: {select, clock, input, pause, protect}
    logic [4:0]            meta_q;
    logic [4:0]            sync_q;
    logic                  sck_prev_q;
    logic                  sel_prev_q;

    snvm_dev_state_e       state_q;
    logic [2:0]            cnt_q;
    logic [6:0]            rx_q;
    logic [AW-1:0]         addr_q;
    snvm_byte_t            tx_q;
    logic                  so_q;
    logic                  rd_q;
    logic                  write_permit_latch_q;
    logic                  clear_pend_q;
    // Nonvolatile bits 7..2 have no reset so a reset acts as a power cycle
    logic [5:0]            nv_q = `SNVM_NV_INIT;
    snvm_byte_t            mem [DEPTH];

    wire                   sel_act;
    wire                   sck_s;
    wire                   si_s;
    wire                   pause_s;
    wire                   wp_s;
    wire                   live;
    wire                   rise;
    wire                   fall;
    wire                   sel_rise;
    wire                   byte_done;
    snvm_byte_t            byte_in;
    snvm_byte_t            status_w;
    wire [AW-1:0]          rd_addr;
    snvm_byte_t            rd_data;
    wire                   state_open;
    wire                   mem_we;
    wire                   nv_we;
    wire                   status_guard_enable;
    wire [1:0]             region_code;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q     <= 5'h1F;
            sync_q     <= 5'h1F;
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end
        else
        begin
            meta_q     <= {link.sel_n, link.sck, link.si, link.pause_n, link.wp_n};
            sync_q     <= meta_q;
            sck_prev_q <= sync_q[3];
            sel_prev_q <= sync_q[4];
        end
    end

    assign sel_act   = !sync_q[4];
    assign sck_s     = sync_q[3];
    assign si_s      = sync_q[2];
    assign pause_s   = !sync_q[1];
    assign wp_s      = sync_q[0];
    // Clock history tracks during a pause too, so release makes no false edge
    assign live      = sel_act && !pause_s;
    // Edges are found, not assumed, so either idle level works
    assign rise      = live && sck_s && !sck_prev_q;
    assign fall      = live && !sck_s && sck_prev_q;
    assign sel_rise  = sync_q[4] && !sel_prev_q;
    assign byte_in   = {rx_q, si_s};
    assign byte_done = rise && (cnt_q == 3'h7);

    assign status_guard_enable = nv_q[`SNVM_ST_GUARD_EN-2];
    assign region_code = nv_q[`SNVM_ST_REGION_HI-2:`SNVM_ST_REGION_LO-2];
    assign status_w  = {nv_q, write_permit_latch_q, 1'b0};

    assign rd_addr   = (state_q == DEV_ADDR_LO)
                       ? {addr_q[AW-1:8], byte_in} : addr_q;
    assign rd_data   = mem[rd_addr];

    assign state_open = write_permit_latch_q
                        && !(status_guard_enable && !wp_s);
    assign mem_we    = byte_done && (state_q == DEV_WDATA)
                       && write_permit_latch_q
                       && !region_locked(region_code, addr_q);
    assign nv_we     = byte_done && (state_q == DEV_WSTATE) && state_open;

    // Array write lands on the last data bit; nothing to wait for
    always_ff @(posedge aclk)
    begin
        if (mem_we)
            mem[addr_q] <= byte_in;
    end

    // Incoming bits 1 and 0 are dropped; spare bits are stored as sent
    always_ff @(posedge aclk)
    begin
        if (nv_we)
            nv_q <= byte_in[7:2];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q              <= DEV_CMD;
            cnt_q                <= 3'h0;
            rx_q                 <= 7'h00;
            addr_q               <= '0;
            tx_q                 <= 8'h00;
            so_q                 <= 1'b0;
            rd_q                 <= 1'b0;
            write_permit_latch_q <= 1'b0;
            clear_pend_q         <= 1'b0;
        end
        else if (!sel_act)
        begin
            // A select dropped mid-byte discards the partial command
            state_q      <= DEV_CMD;
            cnt_q        <= 3'h0;
            clear_pend_q <= 1'b0;
            if (sel_rise && clear_pend_q)
                write_permit_latch_q <= 1'b0;
        end
        else
        begin
            if (rise)
            begin
                rx_q  <= byte_in[6:0];
                cnt_q <= cnt_q + 3'h1;
            end
            if (fall)
                so_q <= tx_q[3'h7 - cnt_q];
            if (byte_done)
            begin
                case (state_q)
                    DEV_CMD:
                    begin
                        state_q <= DEV_SKIP;
                        if (byte_in == `SNVM_OP_SET_WPL)
                            write_permit_latch_q <= 1'b1;
                        else if (byte_in == `SNVM_OP_CLR_WPL)
                            write_permit_latch_q <= 1'b0;
                        else if (byte_in == `SNVM_OP_READ_STATE)
                        begin
                            tx_q    <= status_w;
                            state_q <= DEV_RSTATE;
                        end
                        else if (byte_in == `SNVM_OP_WRITE_STATE)
                        begin
                            clear_pend_q <= 1'b1;
                            state_q      <= DEV_WSTATE;
                        end
                        else if (byte_in == `SNVM_OP_READ_MEM)
                        begin
                            rd_q    <= 1'b1;
                            state_q <= DEV_ADDR_HI;
                        end
                        else if (byte_in == `SNVM_OP_WRITE_MEM)
                        begin
                            rd_q         <= 1'b0;
                            clear_pend_q <= 1'b1;
                            state_q      <= DEV_ADDR_HI;
                        end
                    end
                    DEV_ADDR_HI:
                    begin
                        // Address bits above the array size are ignored
                        addr_q[AW-1:8] <= byte_in[AW-9:0];
                        state_q        <= DEV_ADDR_LO;
                    end
                    DEV_ADDR_LO:
                    begin
                        if (rd_q)
                        begin
                            tx_q    <= rd_data;
                            addr_q  <= rd_addr + 1'b1;
                            state_q <= DEV_RDATA;
                        end
                        else
                        begin
                            addr_q  <= rd_addr;
                            state_q <= DEV_WDATA;
                        end
                    end
                    DEV_WDATA:
                        addr_q <= addr_q + 1'b1;
                    DEV_RDATA:
                    begin
                        // Address wraps at the top of the array
                        tx_q   <= rd_data;
                        addr_q <= addr_q + 1'b1;
                    end
                    DEV_RSTATE:
                        tx_q <= status_w;
                    DEV_WSTATE:
                        state_q <= DEV_SKIP;
                    default:
                        state_q <= DEV_SKIP;
                endcase
            end
        end
    end

    // Slave only: the output is driven solely while a read is answered
    assign link.so    = so_q;
    assign link.so_oe = live && ((state_q == DEV_RDATA)
                                 || (state_q == DEV_RSTATE));
    assign state_byte = status_w;
    assign selected   = sel_act;

endmodule

`default_nettype wire

// file: hdl/snvm_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "snvm_params.svh"

module snvm_host #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    snvm_link_if.host              link
);
    import snvm_pkg::*;

    localparam logic [7:0] HALF_MIN = 8'(`SNVM_SCK_HALF_MIN_CYC);

    logic [ADDR_W-1:0]   aw_q;
    logic                aw_have_q;
    logic [31:0]         w_q;
    logic                w_have_q;
    logic [3:0]          wstrb_q;
    logic [3:0]          ctrl_q;
    snvm_byte_t          txd_q;
    logic [7:0]          div_q;
    snvm_host_state_e    st_q;
    logic [7:0]          tmr_q;
    logic [2:0]          bit_q;
    snvm_byte_t          sh_q;
    snvm_byte_t          rx_q;
    logic                sck_q;
    logic                sel_n_q;
    logic                si_q;
    logic                so_meta_q;
    logic                so_s_q;

    wire                 wr_fire;
    wire                 wr_ctrl;
    wire                 wr_txd;
    wire                 wr_div;
    wire                 wr_hit;
    wire                 rd_hit;
    wire                 go;
    wire                 busy;
    wire                 tick;
    wire [7:0]           half;
    wire [31:0]          rd_mux;
    wire                 keep_sel;
    wire                 idle_high;
    wire                 paused;

    assign keep_sel  = ctrl_q[`SNVM_CTRL_KEEP_SEL-1];
    assign idle_high = ctrl_q[`SNVM_CTRL_IDLE_HIGH-1];
    assign paused    = ctrl_q[`SNVM_CTRL_PAUSE-1];
    assign busy      = (st_q != HST_IDLE);
    assign awready   = !aw_have_q && !bvalid;
    assign wready    = !w_have_q && !bvalid;
    assign arready   = !rvalid;
    assign wr_fire   = aw_have_q && w_have_q && !bvalid;
    assign wr_ctrl   = wr_fire && (aw_q == `SNVM_REG_CTRL);
    assign wr_txd    = wr_fire && (aw_q == `SNVM_REG_TXD);
    assign wr_div    = wr_fire && (aw_q == `SNVM_REG_DIV);
    assign wr_hit    = wr_ctrl || wr_txd || wr_div || (aw_q == `SNVM_REG_STAT);
    assign rd_hit    = (araddr == `SNVM_REG_CTRL) || (araddr == `SNVM_REG_TXD)
                       || (araddr == `SNVM_REG_STAT) || (araddr == `SNVM_REG_DIV);
    // A start while a byte is in flight is dropped
    assign go        = wr_ctrl && wstrb_q[0] && w_q[`SNVM_CTRL_START] && !busy;
    assign half      = (div_q < HALF_MIN) ? HALF_MIN : div_q;
    // Pause freezes the bit timer, so the clock holds its level
    assign tick      = (tmr_q == 8'h00) && !paused;
    assign rd_mux    = (araddr == `SNVM_REG_CTRL) ? {27'h0, ctrl_q, 1'b0}
                     : (araddr == `SNVM_REG_TXD)  ? {24'h0, txd_q}
                     : (araddr == `SNVM_REG_STAT) ? {23'h0, busy, rx_q}
                     : (araddr == `SNVM_REG_DIV)  ? {24'h0, div_q}
                     : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= '0;
            w_q       <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `SNVM_RESP_OKAY;
            rvalid    <= 1'b0;
            rdata     <= 32'h0;
            rresp     <= `SNVM_RESP_OKAY;
            ctrl_q    <= 4'h8;
            txd_q     <= 8'h00;
            div_q     <= `SNVM_DIV_RESET;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_q      <= awaddr;
                aw_have_q <= 1'b1;
            end
            if (wvalid && wready)
            begin
                w_q      <= wdata;
                wstrb_q  <= wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wr_hit ? `SNVM_RESP_OKAY : `SNVM_RESP_SLVERR;
                if (wr_ctrl && wstrb_q[0])
                    ctrl_q <= w_q[4:1];
                if (wr_txd && wstrb_q[0])
                    txd_q <= w_q[7:0];
                if (wr_div && wstrb_q[0])
                    div_q <= w_q[7:0];
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rdata  <= rd_mux;
                rresp  <= rd_hit ? `SNVM_RESP_OKAY : `SNVM_RESP_SLVERR;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            so_meta_q <= 1'b0;
            so_s_q    <= 1'b0;
        end
        else
        begin
            so_meta_q <= link.so;
            so_s_q    <= so_meta_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q    <= HST_IDLE;
            tmr_q   <= 8'h00;
            bit_q   <= 3'h0;
            sh_q    <= 8'h00;
            rx_q    <= 8'h00;
            sck_q   <= 1'b0;
            sel_n_q <= 1'b1;
            si_q    <= 1'b0;
        end
        else
        begin
            if (!tick && !paused && busy)
                tmr_q <= tmr_q - 8'h01;
            case (st_q)
                HST_IDLE:
                begin
                    sck_q <= idle_high;
                    if (go)
                    begin
                        sel_n_q <= 1'b0;
                        si_q    <= txd_q[7];
                        sh_q    <= txd_q;
                        bit_q   <= 3'h0;
                        tmr_q   <= half;
                        st_q    <= HST_SETUP;
                    end
                end
                HST_SETUP:
                    if (tick)
                    begin
                        sck_q <= 1'b0;
                        tmr_q <= half;
                        st_q  <= HST_LOW;
                    end
                HST_LOW:
                    if (tick)
                    begin
                        sck_q <= 1'b1;
                        tmr_q <= half;
                        st_q  <= HST_HIGH;
                    end
                HST_HIGH:
                    if (tick)
                    begin
                        rx_q  <= {rx_q[6:0], so_s_q};
                        tmr_q <= half;
                        if (bit_q == 3'h7)
                        begin
                            sck_q <= idle_high;
                            st_q  <= HST_END;
                        end
                        else
                        begin
                            sck_q <= 1'b0;
                            si_q  <= sh_q[6];
                            sh_q  <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 3'h1;
                            st_q  <= HST_LOW;
                        end
                    end
                default:
                    if (tick)
                    begin
                        if (!keep_sel)
                            sel_n_q <= 1'b1;
                        st_q <= HST_IDLE;
                    end
            endcase
        end
    end

    assign link.sel_n   = sel_n_q;
    assign link.sck     = sck_q;
    // Lines kept apart; si is always driven, so joining them would need a change on this side
    assign link.si      = si_q;
    assign link.pause_n = !paused;
    assign link.wp_n    = ctrl_q[`SNVM_CTRL_WP_LEVEL-1];

endmodule

`default_nettype wire

// file: testbench/snvm_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module snvm_link_assertions (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       sel_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic       pause_n,
    input wire logic       wp_n,
    input wire logic [7:0] state_byte,
    input wire logic       selected
);
    logic       sck_q;
    logic [7:0] age_q;
    logic [7:0] age_d;
    // Saturates so a long idle never wraps into a false match
    assign age_d = !aresetn ? 8'hFF : (sck_q && !sck) ? 8'h00 : age_q + {7'h0, age_q != 8'hFF};
    always_ff @(posedge aclk)
    begin
        sck_q <= sck;
        age_q <= age_d;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence desel_s; sel_n [*4]; endsequence
    sequence sel_s; !sel_n [*4]; endsequence
    sel_float_a: assert property (desel_s |-> !so_oe && !selected)
        else $error("output active while deselected");
    sel_sync_a: assert property (sel_s |-> selected)
        else $error("select not seen");
    pause_float_a: assert property (!pause_n [*4] |-> !so_oe)
        else $error("output active while paused");
    so_fall_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> age_q < 8'h06)
        else $error("output moved away from falling clock");
    so_rise_a: assert property ($rose(sck) && so_oe |-> $stable(so))
        else $error("output moved on rising clock");
    zero_bit_a: assert property (state_byte[0] == 1'h0)
        else $error("state bit 0 set");
    latch_reset_a: assert property ($rose(aresetn) |-> !state_byte[1])
        else $error("latch set after reset");
    sel_lead_a: assert property ($fell(sel_n) |-> $stable(sck) [*4])
        else $error("clock moved with select");
    si_hold_a: assert property ($rose(sck) |-> $stable(si))
        else $error("input moved on rising clock");
    sequence paused_s; !pause_n && !$past(pause_n); endsequence
    sequence held_s; !sel_n && !$past(sel_n); endsequence
    pause_hold_a: assert property (paused_s |-> $stable({sel_n, sck}))
        else $error("pause not held");
    wp_hold_a: assert property (held_s |-> $stable(wp_n))
        else $error("protect pin moved");
endmodule
`default_nettype wire

// file: testbench/tb_spi_nv_memory_slave_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "snvm_params.svh"
module tb_spi_nv_memory_slave_port;
    import snvm_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle, wp;
    logic        awready, wready, bvalid, arready, rvalid, selected;
    logic [7:0]  awaddr, araddr, state_byte, nv, rx, d;
    logic [13:0] a;
    logic [31:0] wdata, rdata, s;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          n_fail, comparisons;
    snvm_link_if link ();
    snvm_host snvm_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link(link));
    snvm_device snvm_device_i (.aclk(aclk), .aresetn(aresetn), .link(link),
        .state_byte(state_byte), .selected(selected));
    snvm_link_assertions snvm_link_assertions_i (.aclk(aclk), .aresetn(aresetn),
        .sel_n(link.sel_n), .sck(link.sck), .si(link.si), .so(link.so), .so_oe(link.so_oe),
        .pause_n(link.pause_n), .wp_n(link.wp_n), .state_byte(state_byte), .selected(selected));
    function automatic logic [7:0] exp_st(input logic [7:0] v);
        return {v[7:2], 2'h0};
    endfunction
    function automatic logic guarded(input logic [7:0] v, input logic [13:0] x);
        return v[3:2] == 2'h3 || (v[3:2] == 2'h2 && x[13]) || (v[3:2] == 2'h1 && &x[13:12]);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        awaddr <= ad;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        resp = bresp;
    endtask
    task automatic rd(input logic [7:0] ad);
        araddr <= ad;
        arvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        s = rdata;
        resp = rresp;
    endtask
    task automatic xfer(input logic [7:0] b, input logic keep);
        wr(`SNVM_REG_TXD, {24'h0, b});
        wr(`SNVM_REG_CTRL, {27'h0, wp, 1'h0, idle, keep, 1'h1});
        s = 32'h100;
        while (s[8]) rd(`SNVM_REG_STAT);
        repeat (4) @(posedge aclk);
        rx = s[7:0];
    endtask
    task automatic mem(input logic [7:0] op, input logic [7:0] v);
        xfer(op, 1'h1);
        xfer({2'h0, a[13:8]}, 1'h1);
        xfer(a[7:0], 1'h1);
        xfer(v, 1'h0);
    endtask
    initial
    begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    initial
    begin
        repeat (90000) @(posedge aclk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, idle, nv, awaddr, araddr, wdata} = '0;
        {bready, rready, wp, wstrb} = 7'h7F;
        void'($urandom(86));
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h10);
        check({6'h0, resp}, {6'h0, `SNVM_RESP_SLVERR});
        wr(8'h10, 32'h0);
        check({6'h0, resp}, {6'h0, `SNVM_RESP_SLVERR});
        for (int m = 0; m < 2; m++)
        begin
            idle = m[0];
            wr(`SNVM_REG_CTRL, {27'h0, wp, 1'h0, idle, 2'h0});
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            check(state_byte, exp_st(nv) | 8'h02);
            xfer(`SNVM_OP_WRITE_STATE, 1'h1);
            xfer(8'hFF, 1'h0);
            check(state_byte, 8'hFC);
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            xfer(`SNVM_OP_WRITE_STATE, 1'h1);
            xfer(8'h00, 1'h0);
            a = 14'($urandom);
            d = 8'($urandom);
            nv = 8'($urandom);
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            mem(`SNVM_OP_WRITE_MEM, d);
            mem(`SNVM_OP_READ_MEM, 8'h00);
            check(rx, d);
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            xfer(`SNVM_OP_WRITE_STATE, 1'h1);
            xfer(nv, 1'h0);
            check(state_byte, exp_st(nv));
            xfer(`SNVM_OP_READ_STATE, 1'h1);
            xfer(8'($urandom), 1'h0);
            check(rx, exp_st(nv));
            xfer(`SNVM_OP_WRITE_STATE, 1'h1);
            xfer(~nv, 1'h0);
            check(state_byte, exp_st(nv));
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            mem(`SNVM_OP_WRITE_MEM, ~d);
            mem(`SNVM_OP_READ_MEM, 8'h00);
            check(rx, guarded(nv, a) ? d : ~d);
            xfer(`SNVM_OP_SET_WPL, 1'h0);
            xfer(`SNVM_OP_CLR_WPL, 1'h0);
            check(state_byte, exp_st(nv));
        end
        wp = 1'h0;
        xfer(`SNVM_OP_SET_WPL, 1'h0);
        xfer(`SNVM_OP_WRITE_STATE, 1'h1);
        xfer(8'h00, 1'h0);
        check(state_byte, {nv[7], 7'h00} | (nv[7] ? exp_st(nv) : 8'h00));
        wp = 1'h1;
        xfer(`SNVM_OP_SET_WPL, 1'h0);
        xfer(`SNVM_OP_WRITE_STATE, 1'h1);
        xfer(8'h80, 1'h0);
        wp = 1'h0;
        xfer(`SNVM_OP_SET_WPL, 1'h0);
        xfer(`SNVM_OP_WRITE_STATE, 1'h1);
        xfer(8'h00, 1'h0);
        check(state_byte, 8'h80);
        xfer(`SNVM_OP_SET_WPL, 1'h0);
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check(state_byte, 8'h80);
        xfer(`SNVM_OP_READ_STATE, 1'h1);
        // Idle high, protect pin low; pause mid-byte, then release
        wr(`SNVM_REG_CTRL, 32'h5);
        repeat (99) @(posedge aclk);
        wr(`SNVM_REG_CTRL, 32'hC);
        repeat (40) @(posedge aclk);
        xfer(8'h00, 1'h0);
        check(rx, 8'h80);
        complete_run();
    end
endmodule
`default_nettype wire
